/* File: core/fes_pkg.sv */
package fes_pkg;

  // core clock period
  localparam int CLK_PERIOD_NS = 5;

  // command codes
  localparam logic [7:0] OP_WRITE_EN = 8'h06;
  localparam logic [7:0] OP_WRITE_DIS = 8'h04;
  localparam logic [7:0] OP_SUB_ERASE_A = 8'h52;
  localparam logic [7:0] OP_SUB_ERASE_B = 8'h20;
  localparam logic [7:0] OP_SECT_ERASE = 8'hD8;
  localparam logic [7:0] OP_CHIP_ERASE_A = 8'hC7;
  localparam logic [7:0] OP_CHIP_ERASE_B = 8'h60;
  localparam logic [7:0] OP_SUSPEND = 8'h75;
  localparam logic [7:0] OP_RESUME = 8'h7A;
  localparam logic [7:0] OP_CLEAR_FLAGS = 8'h50;
  localparam logic [7:0] OP_PROG_A = 8'h02;
  localparam logic [7:0] OP_PROG_B = 8'h12;
  localparam logic [7:0] OP_PROG_C = 8'h82;
  localparam logic [7:0] OP_PROG_D = 8'h84;
  localparam logic [7:0] OP_PROG_E = 8'hC2;
  localparam logic [7:0] OP_PROG_F = 8'h8E;

  // flag status bit positions
  localparam int FL_PROT = 1;
  localparam int FL_PSUSP = 2;
  localparam int FL_PERR = 4;
  localparam int FL_EERR = 5;
  localparam int FL_ESUSP = 6;
  localparam int FL_READY = 7;
  localparam logic [7:0] FLAGS_RESET = 8'h80;

  // frame capture geometry
  localparam int SER_BITS = 40;
  localparam int OCT_BYTES = 6;
  localparam int EDGE_W = 8;
  localparam logic [7:0] EDGE_MAX = 8'hFF;
  localparam logic [7:0] HDR_EXT = 8'h01;
  localparam logic [7:0] HDR_OCT = 8'h02;
  localparam logic [7:0] ALEN_3 = 8'h03;
  localparam logic [7:0] ALEN_4 = 8'h04;

  // address layout
  localparam int SECT_LSB = 17;
  localparam int SECT_W = 8;

  // operation kinds
  localparam logic [1:0] KIND_SUB = 2'h0;
  localparam logic [1:0] KIND_SECT = 2'h1;
  localparam logic [1:0] KIND_CHIP = 2'h2;
  localparam logic [1:0] KIND_PROG = 2'h3;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RUN = 3'b010,
    ST_SWAIT = 3'b100
  } fes_state_e;

endpackage

/* File: core/fes_link.sv */
`timescale 1ns/1ps
`default_nettype none
module fes_link import fes_pkg::*; (
  // link clock and reset
  input wire logic sclk,
  input wire logic rst,
  // frame pins
  input wire logic cs_n,
  input wire logic [7:0] dq,
  // captured frame, stable while the link clock stands
  output logic [EDGE_W-1:0] edges,
  output logic [SER_BITS-1:0] ser,
  output logic [8*OCT_BYTES-1:0] oct
);

  typedef struct packed {
    logic [EDGE_W-1:0] edges;
    logic [SER_BITS-1:0] ser;
    logic [8*OCT_BYTES-1:0] oct;
  } fes_link_s;

  fes_link_s s, n;
  logic fresh;

  // marks the first edge of a frame; cs_n high forces it between frames
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      fresh <= 1'b1;
    end else begin
      fresh <= 1'b0;
    end
  end

  // both serial and octal forms are captured; the core picks one
  always_comb begin
    logic [EDGE_W-1:0] e;
    e = fresh ? '0 : s.edges;
    n = s;
    if (fresh) begin
      n.ser = '0;
      n.oct = '0;
    end
    if (e < EDGE_W'(SER_BITS)) begin
      n.ser[SER_BITS-1-int'(e)] = dq[0];
    end
    if (e < EDGE_W'(OCT_BYTES)) begin
      n.oct[8*OCT_BYTES-1-8*int'(e) -: 8] = dq;
    end
    n.edges = (e == EDGE_MAX) ? EDGE_MAX : e + 1'b1;
  end

  always_ff @(posedge sclk or posedge rst) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign edges = s.edges;
  assign ser = s.ser;
  assign oct = s.oct;

endmodule
`default_nettype wire

/* File: core/fes_ctrl.sv */
// Operation
// - erase needs write enable latch set
// - partial last byte skips erase silently
// - busy shows ready 0, in-progress 1
// - completion clears write enable latch
// - erase timeout sets erase error
// - self-timed duration per erase kind
// - subsector/sector erase addresses its region
// - block-protected target refused, latch kept
// - lock-protected target refused, latch cleared
// - chip erase skips locked sectors
// - suspend sets program or erase flag
// - ready after latency marks suspended
// - short remainder finishes, clears suspend flag
// - flags reset to 80h
// - resume restores latest suspended first
// - suspended sector reported for reads
// - program to suspended sector sets bit 4
// - resume skips lock re-evaluation
// - resume busy, ignored when nothing suspended
// - address length by mode and protocol
`timescale 1ns/1ps
`default_nettype none
module fes_ctrl import fes_pkg::*; #(
  parameter int NSECT = 256,
  parameter int SUBSECTOR_ERASE_TIME_NS = 400000,
  parameter int SECTOR_ERASE_TIME_NS = 1000000,
  parameter int WHOLE_CHIP_ERASE_TIME_NS = 4000000,
  parameter int PROGRAM_TIME_NS = 200000,
  parameter int SUSPEND_LATENCY_NS = 20000
) (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RESET,
  // serial link
  input wire logic SCLK,
  input wire logic CS_N,
  input wire logic [7:0] SERIAL_DATA_LINES,
  // configuration
  input wire logic OCTAL_MODE,
  input wire logic ADDR4_MODE,
  input wire logic [3:0] BLOCK_PROTECT_BITS,
  input wire logic [NSECT-1:0] SECTOR_LOCK_SCHEME,
  // array engine
  input wire logic ARRAY_FAULT,
  output logic ARRAY_START,
  output logic ARRAY_RUN,
  output logic [1:0] ARRAY_KIND,
  output logic [31:0] ARRAY_ADDR,
  output logic ARRAY_SKIP_LOCKED,
  // status
  output logic WIP,
  output logic WEL,
  output logic [7:0] FLAGS,
  output logic SUSP_VALID,
  output logic [SECT_W-1:0] SUSP_SECTOR
);

  // durations: least times round up, the latency rounds down
  localparam logic [31:0] SSE_CYC = 32'((SUBSECTOR_ERASE_TIME_NS
    + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [31:0] SE_CYC = 32'((SECTOR_ERASE_TIME_NS
    + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [31:0] BE_CYC = 32'((WHOLE_CHIP_ERASE_TIME_NS
    + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [31:0] PP_CYC = 32'((PROGRAM_TIME_NS
    + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [31:0] LAT_CYC = (SUSPEND_LATENCY_NS < CLK_PERIOD_NS)
    ? 32'h0000_0001 : 32'(SUSPEND_LATENCY_NS / CLK_PERIOD_NS);

  typedef struct packed {
    logic cs_s1;
    logic cs_s2;
    logic cs_s3;
    fes_state_e state;
    logic wip;
    logic wel;
    logic [7:0] flags;
    logic early;
    logic start;
    logic run;
    logic skip;
    logic [1:0] kind;
    logic [31:0] addr;
    logic [31:0] cnt;
    logic [31:0] lat;
    logic es_valid;
    logic es_skip;
    logic [1:0] es_kind;
    logic [31:0] es_addr;
    logic [31:0] es_cnt;
    logic ps_valid;
    logic [31:0] ps_addr;
    logic [31:0] ps_cnt;
    logic susp_valid;
    logic [SECT_W-1:0] susp_sector;
  } fes_ctrl_s;

  fes_ctrl_s s, n;
  logic [EDGE_W-1:0] lk_edges;
  logic [SER_BITS-1:0] lk_ser;
  logic [8*OCT_BYTES-1:0] lk_oct;

  // link-side capture, clocked by the host's serial clock
  fes_link u_link (
    .sclk(SCLK),
    .rst(RESET),
    .cs_n(CS_N),
    .dq(SERIAL_DATA_LINES),
    .edges(lk_edges),
    .ser(lk_ser),
    .oct(lk_oct)
  );

  function automatic logic [SECT_W-1:0] sect_of(input logic [31:0] a);
    sect_of = a[SECT_LSB +: SECT_W];
  endfunction

  // nonzero protect value guards the top 2^(bp-1) sectors; from 9 up it guards all NSECT sectors
  function automatic logic bp_hit(input logic [3:0] bp,
                                  input logic [SECT_W-1:0] sect);
    int span;
    span = (bp >= 4'h9) ? NSECT : (1 << (int'(bp) - 1));
    bp_hit = (bp != 4'h0) && (int'(sect) >= NSECT - span);
  endfunction

  // frame decode, valid when fend pulses
  logic fend;
  logic [7:0] cmd;
  logic [31:0] f_addr;
  logic [7:0] nbytes;
  logic [7:0] hdr;
  logic [7:0] alen;
  logic partial;
  logic len_plain;
  logic len_addr;
  logic len_prog;
  logic is_sub;
  logic is_sect;
  logic is_chip;
  logic is_prog;
  logic [SECT_W-1:0] f_sect;

  always_comb begin
    fend = s.cs_s2 & ~s.cs_s3;
    cmd = OCTAL_MODE ? lk_oct[8*OCT_BYTES-1 -: 8] : lk_ser[SER_BITS-1 -: 8];
    // octal frames always carry four address bytes
    if (OCTAL_MODE || ADDR4_MODE) begin
      f_addr = OCTAL_MODE ? lk_oct[31:0] : lk_ser[31:0];
    end else begin
      f_addr = {8'h00, lk_ser[31:8]};
    end
    hdr = OCTAL_MODE ? HDR_OCT : HDR_EXT;
    alen = (OCTAL_MODE || ADDR4_MODE) ? ALEN_4 : ALEN_3;
    nbytes = OCTAL_MODE ? lk_edges : (lk_edges >> 3);
    partial = !OCTAL_MODE && (lk_edges[2:0] != 3'h0);
    len_plain = !partial && (nbytes == hdr);
    len_addr = !partial && (nbytes == hdr + alen);
    len_prog = !partial && (nbytes > hdr + alen);
    is_sub = (cmd == OP_SUB_ERASE_A) || (cmd == OP_SUB_ERASE_B);
    is_sect = (cmd == OP_SECT_ERASE);
    is_chip = (cmd == OP_CHIP_ERASE_A) || (cmd == OP_CHIP_ERASE_B);
    is_prog = (cmd == OP_PROG_A) || (cmd == OP_PROG_B) ||
              (cmd == OP_PROG_C) || (cmd == OP_PROG_D) ||
              (cmd == OP_PROG_E) || (cmd == OP_PROG_F);
    f_sect = sect_of(f_addr);
  end

  // one step of the sequencer
  always_comb begin
    n = s;
    n.start = 1'b0;
    n.cs_s1 = CS_N;
    n.cs_s2 = s.cs_s1;
    n.cs_s3 = s.cs_s2;
    // error bits clear first, so a same-cycle set still wins
    if (fend && len_plain && cmd == OP_CLEAR_FLAGS) begin
      n.flags[FL_PROT] = 1'b0;
      n.flags[FL_PERR] = 1'b0;
      n.flags[FL_EERR] = 1'b0;
    end
    // self-timed progress
    case (s.state)
      ST_IDLE: begin
      end
      ST_RUN: begin
        n.cnt = s.cnt - 32'h0000_0001;
        if (s.cnt == 32'h0000_0001) begin
          n.state = ST_IDLE;
          n.wip = 1'b0;
          n.wel = 1'b0;
          n.run = 1'b0;
          n.early = 1'b0;
          if (s.kind == KIND_PROG) begin
            n.flags[FL_PSUSP] = 1'b0;
            n.flags[FL_PERR] = n.flags[FL_PERR] | ARRAY_FAULT;
          end else begin
            n.flags[FL_ESUSP] = 1'b0;
            n.flags[FL_EERR] = n.flags[FL_EERR] | ARRAY_FAULT;
          end
        end
      end
      ST_SWAIT: begin
        n.cnt = s.cnt - 32'h0000_0001;
        n.lat = s.lat - 32'h0000_0001;
        if (s.lat == 32'h0000_0001) begin
          // park the operation; ready comes back up
          n.state = ST_IDLE;
          n.wip = 1'b0;
          n.run = 1'b0;
          if (s.kind == KIND_PROG) begin
            n.ps_valid = 1'b1;
            n.ps_addr = s.addr;
            n.ps_cnt = n.cnt;
          end else begin
            n.es_valid = 1'b1;
            n.es_skip = s.skip;
            n.es_kind = s.kind;
            n.es_addr = s.addr;
            n.es_cnt = n.cnt;
          end
        end
      end
      default: begin
        n.state = ST_IDLE;
      end
    endcase
    // commands, taken at the end of each frame
    if (fend) begin
      if (len_plain && s.state == ST_IDLE && cmd == OP_WRITE_EN) begin
        n.wel = 1'b1;
      end
      if (len_plain && s.state == ST_IDLE && cmd == OP_WRITE_DIS) begin
        n.wel = 1'b0;
      end
      // suspend acts only on a running operation
      if (len_plain && cmd == OP_SUSPEND && n.state == ST_RUN &&
          !s.early) begin
        if (s.kind == KIND_PROG) begin
          n.flags[FL_PSUSP] = 1'b1;
        end else begin
          n.flags[FL_ESUSP] = 1'b1;
        end
        if (n.cnt <= LAT_CYC) begin
          n.early = 1'b1;
        end else begin
          n.state = ST_SWAIT;
          n.lat = LAT_CYC;
        end
      end
      // latest suspended first; locks are not looked at again
      if (len_plain && cmd == OP_RESUME && s.state == ST_IDLE) begin
        if (s.ps_valid) begin
          n.ps_valid = 1'b0;
          n.flags[FL_PSUSP] = 1'b0;
          n.kind = KIND_PROG;
          n.addr = s.ps_addr;
          n.cnt = s.ps_cnt;
          n.skip = 1'b0;
        end else if (s.es_valid) begin
          n.es_valid = 1'b0;
          n.flags[FL_ESUSP] = 1'b0;
          n.kind = s.es_kind;
          n.addr = s.es_addr;
          n.cnt = s.es_cnt;
          n.skip = s.es_skip;
        end
        if (s.ps_valid || s.es_valid) begin
          n.state = ST_RUN;
          n.wip = 1'b1;
          n.run = 1'b1;
          n.start = 1'b1;
        end
      end
      // erases only from standby; a short frame is dropped
      if (s.state == ST_IDLE && !s.es_valid && !s.ps_valid && s.wel &&
          (((is_sub || is_sect) && len_addr) || (is_chip && len_plain))) begin
        if (is_chip && BLOCK_PROTECT_BITS != 4'h0) begin
          n.flags[FL_PROT] = 1'b1;
          n.flags[FL_EERR] = 1'b1;
        end else if (!is_chip && bp_hit(BLOCK_PROTECT_BITS, f_sect)) begin
          n.flags[FL_PROT] = 1'b1;
          n.flags[FL_EERR] = 1'b1;
        end else if (!is_chip && SECTOR_LOCK_SCHEME[f_sect]) begin
          n.wel = 1'b0;
          n.flags[FL_PROT] = 1'b1;
          n.flags[FL_EERR] = 1'b1;
        end else begin
          n.state = ST_RUN;
          n.wip = 1'b1;
          n.run = 1'b1;
          n.start = 1'b1;
          n.addr = f_addr;
          n.skip = is_chip && (|SECTOR_LOCK_SCHEME);
          if (is_chip) begin
            n.kind = KIND_CHIP;
            n.cnt = BE_CYC;
          end else if (is_sub) begin
            n.kind = KIND_SUB;
            n.cnt = SSE_CYC;
          end else begin
            n.kind = KIND_SECT;
            n.cnt = SE_CYC;
          end
        end
      end
      // program is allowed beside a suspended erase, not into it
      if (s.state == ST_IDLE && !s.ps_valid && s.wel && is_prog &&
          len_prog) begin
        if (s.es_valid && sect_of(s.es_addr) == f_sect) begin
          n.flags[FL_PERR] = 1'b1;
        end else begin
          n.state = ST_RUN;
          n.wip = 1'b1;
          n.run = 1'b1;
          n.start = 1'b1;
          n.addr = f_addr;
          n.skip = 1'b0;
          n.kind = KIND_PROG;
          n.cnt = PP_CYC;
        end
      end
    end
    n.flags[FL_READY] = !n.wip;
    // registered so the read-side view never glitches
    n.susp_valid = n.es_valid | n.ps_valid;
    n.susp_sector = n.es_valid ? sect_of(n.es_addr) : sect_of(n.ps_addr);
  end

  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      s <= '0;
      s.state <= ST_IDLE;
      s.cs_s1 <= 1'b1;
      s.cs_s2 <= 1'b1;
      s.cs_s3 <= 1'b1;
      s.flags <= FLAGS_RESET;
    end else begin
      s <= n;
    end
  end

  // outputs straight from the state register
  assign ARRAY_START = s.start;
  assign ARRAY_RUN = s.run;
  assign ARRAY_KIND = s.kind;
  assign ARRAY_ADDR = s.addr;
  assign ARRAY_SKIP_LOCKED = s.skip;
  assign WIP = s.wip;
  assign WEL = s.wel;
  assign FLAGS = s.flags;
  assign SUSP_VALID = s.susp_valid;
  assign SUSP_SECTOR = s.susp_sector;

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RESET);

  ready_wip_a: assert property (FLAGS[FL_READY] == !WIP)
    else $error("ready flag disagrees with busy");
  done_wel_a: assert property (s.state == ST_RUN && s.cnt == 32'h0000_0001
    |=> !WEL && !WIP)
    else $error("latch not cleared at completion");
  fault_a: assert property (s.state == ST_RUN && s.kind != KIND_PROG &&
    s.cnt == 32'h0000_0001 && ARRAY_FAULT |=> FLAGS[FL_EERR])
    else $error("erase fault not flagged");
  no_wel_a: assert property (fend && !s.wel && s.state == ST_IDLE &&
    (is_sub || is_sect || is_chip) |=> $stable(FLAGS) && !WIP)
    else $error("erase ran without write enable");
  partial_a: assert property (fend && partial && s.state == ST_IDLE
    |=> !ARRAY_START && $stable(FLAGS) && $stable(WEL))
    else $error("partial frame acted on");
  bp_a: assert property (fend && s.wel && s.state == ST_IDLE &&
    !s.es_valid && !s.ps_valid && (is_sub || is_sect) && len_addr &&
    bp_hit(BLOCK_PROTECT_BITS, f_sect)
    |=> WEL && FLAGS[FL_PROT] && FLAGS[FL_EERR] && !WIP)
    else $error("protected erase not refused");
  lock_a: assert property (fend && s.wel && s.state == ST_IDLE &&
    !s.es_valid && !s.ps_valid && (is_sub || is_sect) && len_addr &&
    !bp_hit(BLOCK_PROTECT_BITS, f_sect) && SECTOR_LOCK_SCHEME[f_sect]
    |=> !WEL && FLAGS[FL_PROT] && !WIP)
    else $error("locked erase not refused");
  idle_susp_a: assert property (fend && len_plain && cmd == OP_SUSPEND &&
    s.state == ST_IDLE |=> $stable(FLAGS) && $stable(WIP))
    else $error("suspend while idle changed state");
  park_a: assert property (s.state == ST_SWAIT && s.lat == 32'h0000_0001
    |=> FLAGS[FL_READY] ##1 FLAGS[FL_READY])
    else $error("ready not raised after latency");
  nest_a: assert property (fend && len_plain && cmd == OP_RESUME &&
    s.state == ST_IDLE && s.ps_valid && s.es_valid
    |=> ARRAY_KIND == KIND_PROG && SUSP_VALID && WIP)
    else $error("resume order wrong");
  empty_resume_a: assert property (fend && len_plain && cmd == OP_RESUME &&
    !s.ps_valid && !s.es_valid |=> !ARRAY_START)
    else $error("resume with nothing suspended");
  start_pulse_a: assert property (ARRAY_START |-> WIP ##1 !ARRAY_START)
    else $error("start not a single pulse");

  erase_done_c: cover property (s.state == ST_RUN && s.kind != KIND_PROG
    && s.cnt == 32'h0000_0001);
  nested_c: cover property (s.es_valid && s.ps_valid);
  refuse_c: cover property (fend && FLAGS[FL_PROT] == 1'b0 ##1
    FLAGS[FL_PROT]);
  early_c: cover property (s.early && s.state == ST_RUN);

endmodule
`default_nettype wire

/* File: sim/fes_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// host side of the serial link; its clock runs only inside frames
module fes_host_model (
  // link pins
  output logic sclk,
  output logic cs_n,
  output logic [7:0] data
);
  // idle: clock low, chip deselected
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    data = 8'h00;
  end

  // one frame msb first; in serial frames xbits adds a ragged tail of clocks
  task automatic send(input logic [63:0] d, input int nb, input int xbits,
                      input logic oct);
    int n;
    n = oct ? nb : nb * 8 + xbits;
    #3.3 cs_n = 1'b0; // select falls before the first edge
    for (int i = 0; i < n; i++) begin
      data = oct ? d[63-8*(i%8) -: 8] : {~data[7:1], d[63-(i%64)]};
      #16 sclk = 1'b1;
      #16 sclk = 1'b0;
    end
    #16 cs_n = 1'b1; // only after the last clock, ragged tail included
    data = ~data; // released lines must not keep the last value
    #40; // deselect gap well above four core cycles
  endtask
endmodule
`default_nettype wire

/* File: sim/fes_ctrl_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module fes_ctrl_tb import fes_pkg::*; ;
  localparam int SUB = 500 / CLK_PERIOD_NS;
  localparam int SECT = 1000 / CLK_PERIOD_NS;
  localparam int CHIP = 2000 / CLK_PERIOD_NS;
  localparam int LAT = 50 / CLK_PERIOD_NS;
  typedef struct {logic [9:0] st; int cyc;} fes_stn_s;
  typedef struct {logic [1:0] k; logic skip; logic [31:0] a; logic ca;} fes_gon_s;
  logic CORE_CLK, RESET, OCTAL_MODE, ADDR4_MODE, ARRAY_FAULT;
  logic [3:0] BLOCK_PROTECT_BITS;
  logic [255:0] SECTOR_LOCK_SCHEME;
  wire SCLK, CS_N;
  wire [7:0] SERIAL_DATA_LINES;
  logic ARRAY_START, ARRAY_RUN, ARRAY_SKIP_LOCKED, WIP, WEL, SUSP_VALID;
  logic [1:0] ARRAY_KIND;
  logic [31:0] ARRAY_ADDR, ae, ap;
  logic [7:0] FLAGS, SUSP_SECTOR, se;
  fes_stn_s st_q[$];
  fes_gon_s go_q[$];
  int num_errors = 0, checks_done = 0, since = 0, seed = 32'h48ef;
  logic [9:0] prev_st = 10'h080;
  logic [7:0] ops [5] = '{OP_SUB_ERASE_A, OP_SUB_ERASE_B, OP_SECT_ERASE,
                          OP_CHIP_ERASE_A, OP_CHIP_ERASE_B};
  int dur [5] = '{SUB, SUB, SECT, CHIP, CHIP};

  fes_host_model i_fes_host_model (.sclk(SCLK), .cs_n(CS_N),
    .data(SERIAL_DATA_LINES));
  fes_ctrl #(.SUBSECTOR_ERASE_TIME_NS(500), .SECTOR_ERASE_TIME_NS(1000),
    .WHOLE_CHIP_ERASE_TIME_NS(2000), .PROGRAM_TIME_NS(300),
    .SUSPEND_LATENCY_NS(50)) i_fes_ctrl (.CORE_CLK(CORE_CLK), .RESET(RESET),
    .SCLK(SCLK), .CS_N(CS_N), .SERIAL_DATA_LINES(SERIAL_DATA_LINES),
    .OCTAL_MODE(OCTAL_MODE), .ADDR4_MODE(ADDR4_MODE),
    .BLOCK_PROTECT_BITS(BLOCK_PROTECT_BITS),
    .SECTOR_LOCK_SCHEME(SECTOR_LOCK_SCHEME), .ARRAY_FAULT(ARRAY_FAULT),
    .ARRAY_START(ARRAY_START), .ARRAY_RUN(ARRAY_RUN), .ARRAY_KIND(ARRAY_KIND),
    .ARRAY_ADDR(ARRAY_ADDR), .ARRAY_SKIP_LOCKED(ARRAY_SKIP_LOCKED), .WIP(WIP),
    .WEL(WEL), .FLAGS(FLAGS), .SUSP_VALID(SUSP_VALID),
    .SUSP_SECTOR(SUSP_SECTOR));

  // core clock
  initial begin
    CORE_CLK = 1'b0;
    forever #(CLK_PERIOD_NS / 2.0) CORE_CLK = ~CORE_CLK;
  end

  task automatic chk(input string what, input logic [39:0] exp,
                     input logic [39:0] got);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // durations get two cycles of slack for the synchroniser phase
  task automatic cmp_st(input fes_stn_s n, input logic [9:0] got, input int c);
    chk("status", {30'h0, n.st}, {30'h0, got});
    if (n.cyc != 0)
      chk("duration", 40'h1, {39'h0, c >= n.cyc - 2 && c <= n.cyc + 2});
  endtask

  task automatic cmp_go(input fes_gon_s g);
    chk("start_kind", {37'h0, g.skip, g.k},
        {37'h0, ARRAY_SKIP_LOCKED, ARRAY_KIND});
    chk("start_run", 40'h1, {39'h0, ARRAY_RUN});
    if (g.ca)
      chk("start_addr", {8'h00, g.a}, {8'h00, ARRAY_ADDR});
  endtask

  // watcher: each status change and start pulse takes the oldest note
  always @(negedge CORE_CLK) begin
    if (!RESET) begin
      if ({WIP, WEL, FLAGS} !== prev_st) begin
        if (st_q.size() == 0)
          chk("status_extra", {30'h0, prev_st}, {30'h0, WIP, WEL, FLAGS});
        else
          cmp_st(st_q.pop_front(), {WIP, WEL, FLAGS}, since);
        since = 0;
      end else
        since++;
      prev_st = {WIP, WEL, FLAGS};
      if (ARRAY_START === 1'b1) begin
        if (go_q.size() == 0)
          chk("start_extra", 40'h0, 40'h1);
        else
          cmp_go(go_q.pop_front());
      end
    end
  end

  task automatic cyc(input int n);
    repeat (n) @(negedge CORE_CLK);
  endtask

  // bounded wait until every note has been consumed
  task automatic wait_q(input int lim);
    int k;
    k = 0;
    while ((st_q.size() != 0 || go_q.size() != 0) && k < lim) begin
      @(negedge CORE_CLK);
      k++;
    end
    if (st_q.size() != 0 || go_q.size() != 0) begin
      num_errors++;
      $display("[ERR] wait_q expected 0 seen %0d", st_q.size());
      end_sim();
    end
  endtask

  task automatic cfg(input logic o, input logic a4, input logic [3:0] pr,
                     input logic [255:0] lk, input logic f);
    @(posedge CORE_CLK);
    OCTAL_MODE <= o;
    ADDR4_MODE <= a4;
    BLOCK_PROTECT_BITS <= pr;
    SECTOR_LOCK_SCHEME <= lk;
    ARRAY_FAULT <= f;
    @(negedge CORE_CLK);
  endtask

  function automatic logic [31:0] adr(input logic [7:0] s);
    logic [31:0] r;
    r = $random(seed);
    return {7'h00, s, r[16:0]};
  endfunction

  task automatic st(input logic [9:0] v, input int c);
    st_q.push_back('{v, c});
  endtask

  // address length follows framing and address mode
  task automatic frame(input logic [7:0] op, input logic [31:0] a,
                       input int na, input int xb);
    logic [63:0] d;
    int nb;
    nb = (na > 0 ? (OCTAL_MODE || ADDR4_MODE ? 4 : 3) : 0) + int'(na == 2);
    if (OCTAL_MODE)
      d = {op, 8'h00, a, 16'h0};
    else if (ADDR4_MODE)
      d = {op, a, 24'h0};
    else
      d = {op, a[23:0], 32'h0};
    nb += OCTAL_MODE ? 2 : 1;
    i_fes_host_model.send(d, nb, xb, OCTAL_MODE);
  endtask

  // write enable, then an erase whose start is expected
  task automatic run(input logic [7:0] op, input logic [1:0] k,
                     input logic [31:0] a);
    st(10'h180, 0);
    frame(OP_WRITE_EN, 32'h0, 0, 0);
    go_q.push_back('{k, 1'b0, a, k != KIND_CHIP});
    st(10'h300, 0);
    frame(op, a, int'(k != KIND_CHIP), 0);
  endtask

  initial begin
    RESET = 1'b1;
    OCTAL_MODE = 1'b0;
    ADDR4_MODE = 1'b0;
    ARRAY_FAULT = 1'b0;
    BLOCK_PROTECT_BITS = 4'h0;
    SECTOR_LOCK_SCHEME = '0;
    cyc(20);
    @(posedge CORE_CLK);
    RESET <= 1'b0;
    cyc(2);
    chk("flags_reset", 40'h80, {32'h0, FLAGS});
    // idle suspend, idle resume, erase without write enable
    frame(OP_SUSPEND, 32'h0, 0, 0);
    frame(OP_RESUME, 32'h0, 0, 0);
    frame(OP_SECT_ERASE, adr(8'h05), 1, 0);
    st(10'h180, 0);
    frame(OP_WRITE_EN, 32'h0, 0, 0);
    frame(OP_SECT_ERASE, adr(8'h05), 1, 3);
    cyc(20);
    chk("wel_kept", 40'h1, {39'h0, WEL});
    st(10'h080, 0);
    frame(OP_WRITE_DIS, 32'h0, 0, 0);
    // every erase code across the three framings
    for (int i = 0; i < 5; i++) begin
      cfg(i == 2 || i == 4, i == 1, 4'h0, '0, 1'b0);
      ae = adr({i == 1, 7'(i * 37)});
      run(ops[i], i < 2 ? KIND_SUB : (i == 2 ? KIND_SECT : KIND_CHIP), ae);
      st(10'h080, dur[i]);
      wait_q(1000);
    end
    // timed-out erase
    cfg(1'b1, 1'b0, 4'h0, '0, 1'b1);
    run(OP_SECT_ERASE, KIND_SECT, ae);
    st(10'h0A0, 0);
    wait_q(1000);
    cfg(1'b0, 1'b1, 4'h1, '0, 1'b0);
    st(10'h080, 0);
    frame(OP_CLEAR_FLAGS, 32'h0, 0, 0);
    // top sector guarded by protect bits, then locked sector 3
    st(10'h180, 0);
    frame(OP_WRITE_EN, 32'h0, 0, 0);
    st(10'h1A2, 0);
    frame(OP_SECT_ERASE, adr(8'hFF), 1, 0);
    st(10'h180, 0);
    frame(OP_CLEAR_FLAGS, 32'h0, 0, 0);
    st(10'h1A2, 0);
    frame(OP_CHIP_ERASE_A, 32'h0, 0, 0);
    st(10'h180, 0);
    frame(OP_CLEAR_FLAGS, 32'h0, 0, 0);
    cfg(1'b0, 1'b1, 4'h0, 256'h8, 1'b0);
    st(10'h0A2, 0);
    frame(OP_SECT_ERASE, adr(8'h03), 1, 0);
    st(10'h080, 0);
    frame(OP_CLEAR_FLAGS, 32'h0, 0, 0);
    st(10'h180, 0);
    frame(OP_WRITE_EN, 32'h0, 0, 0);
    go_q.push_back('{KIND_CHIP, 1'b1, 32'h0, 1'b0});
    st(10'h300, 0);
    st(10'h080, CHIP);
    frame(OP_CHIP_ERASE_B, 32'h0, 0, 0);
    wait_q(1000);
    // erase suspended, program nested inside it
    cfg(1'b1, 1'b0, 4'h0, '0, 1'b0);
    se = 8'h0C;
    ae = adr(se);
    ap = adr(8'h21);
    run(OP_SECT_ERASE, KIND_SECT, ae);
    wait_q(100);
    cyc(20);
    st(10'h340, 0);
    st(10'h1C0, LAT);
    frame(OP_SUSPEND, 32'h0, 0, 0);
    wait_q(100); // ready seen before treating it as suspended
    chk("susp_sect", {31'h0, 1'b1, se}, {31'h0, SUSP_VALID, SUSP_SECTOR});
    cfg(1'b1, 1'b0, 4'h0, 256'h1000, 1'b0); // lock changed meanwhile
    st(10'h1D0, 0);
    frame(OP_PROG_A, adr(se), 2, 0);
    go_q.push_back('{KIND_PROG, 1'b0, ap, 1'b1});
    st(10'h350, 0);
    frame(OP_PROG_A, ap, 2, 0);
    wait_q(100);
    st(10'h354, 0);
    st(10'h1D4, 0);
    frame(OP_SUSPEND, 32'h0, 0, 0);
    wait_q(100);
    go_q.push_back('{KIND_PROG, 1'b0, ap, 1'b1});
    st(10'h350, 0);
    st(10'h0D0, 0);
    frame(OP_RESUME, 32'h0, 0, 0);
    wait_q(200);
    go_q.push_back('{KIND_SECT, 1'b0, ae, 1'b1});
    st(10'h210, 0);
    st(10'h090, 0);
    frame(OP_RESUME, 32'h0, 0, 0);
    wait_q(500);
    cfg(1'b1, 1'b0, 4'h0, '0, 1'b0);
    st(10'h080, 0);
    frame(OP_CLEAR_FLAGS, 32'h0, 0, 0);
    // suspend too close to the end: operation simply finishes
    run(OP_SUB_ERASE_A, KIND_SUB, ae);
    wait_q(100);
    cyc(72);
    st(10'h340, 0);
    st(10'h080, 0);
    frame(OP_SUSPEND, 32'h0, 0, 0);
    wait_q(200);
    // reset while suspended drops the suspension
    run(OP_SECT_ERASE, KIND_SECT, ae);
    wait_q(100);
    st(10'h340, 0);
    st(10'h1C0, 0);
    frame(OP_SUSPEND, 32'h0, 0, 0);
    wait_q(100);
    st(10'h080, 0);
    RESET = 1'b1;
    cyc(3);
    @(posedge CORE_CLK);
    RESET <= 1'b0;
    cyc(2);
    chk("susp_lost", 40'h0, {39'h0, SUSP_VALID});
    wait_q(20);
    end_sim();
  end
endmodule
`default_nettype wire
